// >>> rtl/gpb_pkg.sv
package gpb_pkg;

  // ----------------------------------------------------------------
  // Port set geometry
  // ----------------------------------------------------------------
  localparam int PORT_CNT = 15;
  localparam int PIN_W = 8;
  localparam int PORT_IDX_W = 4;
  localparam int WB_DAT_W = 32;
  localparam int WB_SEL_W = 4;

  // Port slot numbers (slot order is the register map order)
  localparam logic [PORT_IDX_W-1:0] SLOT_P1 = 4'h0;
  localparam logic [PORT_IDX_W-1:0] SLOT_P2 = 4'h1;
  localparam logic [PORT_IDX_W-1:0] SLOT_P3 = 4'h2;
  localparam logic [PORT_IDX_W-1:0] SLOT_P4 = 4'h3;
  localparam logic [PORT_IDX_W-1:0] SLOT_P5 = 4'h4;
  localparam logic [PORT_IDX_W-1:0] SLOT_P9 = 4'h5;
  localparam logic [PORT_IDX_W-1:0] SLOT_PA = 4'h6;
  localparam logic [PORT_IDX_W-1:0] SLOT_PK = 4'hE;

  // Feature masks, one bit per slot, bit 0 is port 1
  localparam logic [PORT_CNT-1:0] HAS_OUT = 15'h7FD7;
  localparam logic [PORT_CNT-1:0] HAS_PUP = 15'h07C0;
  localparam logic [PORT_CNT-1:0] HAS_ODR = 15'h01C4;

  // Implemented pins per port
  localparam logic [PIN_W-1:0] PINS_FULL = 8'hFF;
  localparam logic [PIN_W-1:0] PINS_P5 = 8'h07;

  // ----------------------------------------------------------------
  // Register map: byte address = slot * PORT_STRIDE + offset
  // ----------------------------------------------------------------
  localparam logic [8:0] PORT_STRIDE = 9'h020;
  localparam int SLOT_LSB = 5;
  localparam logic [4:0] OFS_DIR = 5'h00;
  localparam logic [4:0] OFS_LATCH = 5'h04;
  localparam logic [4:0] OFS_PIN = 5'h08;
  localparam logic [4:0] OFS_PULLUP = 5'h0C;
  localparam logic [4:0] OFS_ODR = 5'h10;

  // Reset values
  localparam logic [PIN_W-1:0] RST_DIR = 8'h00;
  localparam logic [PIN_W-1:0] RST_LATCH = 8'h00;
  localparam logic [PIN_W-1:0] RST_PULLUP = 8'h00;
  localparam logic [PIN_W-1:0] RST_ODR = 8'h00;
  localparam logic [PIN_W-1:0] RST_PIN = 8'h00;

  // Register selected by an access
  typedef enum logic [2:0] {
    GPB_REG_DIR,
    GPB_REG_LATCH,
    GPB_REG_PIN,
    GPB_REG_PULLUP,
    GPB_REG_ODR,
    GPB_REG_NONE
  } gpb_reg_e;

  // Pins that exist on a port slot
  function automatic logic [PIN_W-1:0] gpb_pin_mask(input logic [PORT_IDX_W-1:0] slot);
    gpb_pin_mask = (slot == SLOT_P5) ? PINS_P5 : PINS_FULL;
  endfunction

endpackage

// >>> rtl/gpb_reg_if.sv
`timescale 1ns/1ns
interface gpb_reg_if;
  import gpb_pkg::*;

  // One-cycle write strobe and the decoded access
  logic wr;
  logic [PORT_IDX_W-1:0] slot;
  gpb_reg_e regn;
  logic [PIN_W-1:0] wdata;
  // Read value of the decoded register, combinational
  logic [PIN_W-1:0] rdata;

  modport bus (output wr, output slot, output regn, output wdata, input rdata);
  modport core (input wr, input slot, input regn, input wdata, output rdata);

endinterface

// >>> rtl/gpb_pin_sync.sv
`timescale 1ns/1ns
module gpb_pin_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Raw pins and filtered level
  input wire logic [W-1:0] raw,
  output logic [W-1:0] level
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } gpb_sync_s;

  gpb_sync_s cur_ff;
  gpb_sync_s nxt_ff;

  // Three stages; s1 feeds only s2 so metastability stays contained
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.s1 = raw;
    nxt_ff.s2 = cur_ff.s1;
    nxt_ff.s3 = cur_ff.s2;
    // A bit moves only when stages two and three agree
    nxt_ff.lvl = (~(cur_ff.s2 ^ cur_ff.s3) & cur_ff.s3) | ((cur_ff.s2 ^ cur_ff.s3) & cur_ff.lvl);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign level = cur_ff.lvl;

endmodule

// >>> rtl/gpb_wb_slave.sv
`timescale 1ns/1ns
module gpb_wb_slave
  import gpb_pkg::*;
#(
  parameter int ADR_W = 12
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [WB_SEL_W-1:0] wb_sel_i,
  input wire logic [WB_DAT_W-1:0] wb_dat_i,
  output logic [WB_DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Register access toward the core
  gpb_reg_if.bus regs
);

  typedef struct packed {
    logic ack;
    logic [PIN_W-1:0] dat;
  } gpb_wb_s;

  gpb_wb_s cur_ff;
  gpb_wb_s nxt_ff;
  logic req;
  logic [4:0] ofs;
  logic [ADR_W-1:0] slot_base;

  // Fresh request; the ack cycle itself is not a second request
  assign req = wb_cyc_i & wb_stb_i & ~cur_ff.ack;
  assign ofs = wb_adr_i[4:0];
  assign regs.slot = wb_adr_i[SLOT_LSB +: PORT_IDX_W];
  assign slot_base = ADR_W'(regs.slot) << SLOT_LSB;
  assign regs.wdata = wb_dat_i[PIN_W-1:0];
  // Data sits in byte lane 0 only
  assign regs.wr = req & wb_we_i & wb_sel_i[0];

  // Address decode; anything outside the map reads zero
  always_comb begin
    if (wb_adr_i != slot_base + ADR_W'(ofs)) begin
      regs.regn = GPB_REG_NONE;
    end else if (regs.slot >= PORT_IDX_W'(PORT_CNT)) begin
      regs.regn = GPB_REG_NONE;
    end else if (ofs == OFS_DIR) begin
      regs.regn = GPB_REG_DIR;
    end else if (ofs == OFS_LATCH) begin
      regs.regn = GPB_REG_LATCH;
    end else if (ofs == OFS_PIN) begin
      regs.regn = GPB_REG_PIN;
    end else if (ofs == OFS_PULLUP) begin
      regs.regn = GPB_REG_PULLUP;
    end else if (ofs == OFS_ODR) begin
      regs.regn = GPB_REG_ODR;
    end else begin
      regs.regn = GPB_REG_NONE;
    end
  end

  // Answer one cycle after the request, ack lasts a single cycle
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.ack = req;
    if (req) begin
      nxt_ff.dat = regs.rdata;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign wb_ack_o = cur_ff.ack;
  assign wb_dat_o = {{(WB_DAT_W-PIN_W){1'b0}}, cur_ff.dat};

endmodule

// >>> rtl/gpb_top.sv
// Added by the designer: register access over Wishbone and the register offsets.
`timescale 1ns/1ns
// Functional notes
// R1: Thirteen bidirectional ports, ports 4 and 9 input-only
// R2: Per-pin direction register on each bidirectional port
// R3: Output latch drives every pin set output
// R4: Pin-state register reads sampled pin levels
// R5: Input-only ports lack direction and output latch
// R6: Ports A to E have pull-up control
// R7: Port 3, A to C: open-drain control
// R8: Port 1 is eight pins wide
// R9: Port 5 three pins; all registers reset zero
module gpb_top
  import gpb_pkg::*;
#(
  parameter int ADR_W = 12
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [WB_SEL_W-1:0] wb_sel_i,
  input wire logic [WB_DAT_W-1:0] wb_dat_i,
  output logic [WB_DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Port pins, slot 0 is port 1
  input wire logic [PORT_CNT-1:0][PIN_W-1:0] pin_in,
  output logic [PORT_CNT-1:0][PIN_W-1:0] pin_out,
  output logic [PORT_CNT-1:0][PIN_W-1:0] pin_oe_n,
  // Internal pull-up switches
  output logic [PORT_CNT-1:0][PIN_W-1:0] pullup_on
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [PORT_CNT-1:0][PIN_W-1:0] dir;
    logic [PORT_CNT-1:0][PIN_W-1:0] output_latch_reg;
    logic [PORT_CNT-1:0][PIN_W-1:0] pullup_control_reg;
    logic [PORT_CNT-1:0][PIN_W-1:0] open_drain_control_reg;
  } gpb_state_s;

  gpb_state_s cur_ff;
  gpb_state_s nxt_ff;
  gpb_reg_if regs ();
  logic [PORT_CNT-1:0][PIN_W-1:0] pin_lvl;
  logic [PORT_CNT*PIN_W-1:0] pin_lvl_flat;
  // Bits each slot implements, one mask per feature
  logic [PORT_CNT-1:0][PIN_W-1:0] out_mask;
  logic [PORT_CNT-1:0][PIN_W-1:0] pup_mask;
  logic [PORT_CNT-1:0][PIN_W-1:0] odr_mask;
  logic [PORT_CNT-1:0][PIN_W-1:0] pin_mask;
  // Filtered pin levels with absent pins forced low
  logic [PORT_CNT-1:0][PIN_W-1:0] pin_view;
  // Decoded write strobes
  logic [PORT_CNT-1:0] slot_hit;
  logic wr_dir;
  logic wr_latch;
  logic wr_pullup;
  logic wr_odr;
  // Addressed slot's register values for the read mux
  logic [PIN_W-1:0] rd_dir;
  logic [PIN_W-1:0] rd_latch;
  logic [PIN_W-1:0] rd_pin;
  logic [PIN_W-1:0] rd_pullup;
  logic [PIN_W-1:0] rd_odr;
  // Pin driver terms
  logic [PORT_CNT-1:0][PIN_W-1:0] high_off;
  logic [PORT_CNT-1:0][PIN_W-1:0] drive_en;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Bits a slot really implements for a given feature
  function automatic logic [PIN_W-1:0] feature_bits(
    input logic [PORT_IDX_W-1:0] slot,
    input logic [PORT_CNT-1:0] present
  );
    logic [PIN_W-1:0] m;
    m = gpb_pin_mask(slot); // R8 R9
    if (!present[slot]) begin
      m = '0; // R5
    end
    feature_bits = m;
  endfunction

  // One-hot slot select; an index past the last port selects none
  function automatic logic [PORT_CNT-1:0] slot_onehot(input logic [PORT_IDX_W-1:0] slot);
    logic [PORT_CNT-1:0] hit;
    hit = '0;
    for (int p = 0; p < PORT_CNT; p++) begin
      if (slot == PORT_IDX_W'(p)) begin
        hit[p] = 1'b1;
      end
    end
    slot_onehot = hit;
  endfunction

  // ----------------------------------------------------------------
  // Bus slave and pin synchroniser
  // ----------------------------------------------------------------
  gpb_wb_slave #(
    .ADR_W(ADR_W)
  ) u_wb (
    .ref_clk(ref_clk),
    .rst(rst),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .regs(regs.bus)
  );

  // Pins are asynchronous to ref_clk, so every level is filtered
  gpb_pin_sync #(
    .W(PORT_CNT * PIN_W)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .raw(pin_in),
    .level(pin_lvl_flat)
  );

  assign pin_lvl = pin_lvl_flat;

  // ----------------------------------------------------------------
  // Feature masks and pin view
  // ----------------------------------------------------------------

  // Fixed per slot; a bit outside its mask can never be set
  always_comb begin
    for (int p = 0; p < PORT_CNT; p++) begin
      out_mask[p] = feature_bits(PORT_IDX_W'(p), HAS_OUT); // R1 R5
      pup_mask[p] = feature_bits(PORT_IDX_W'(p), HAS_PUP); // R6
      odr_mask[p] = feature_bits(PORT_IDX_W'(p), HAS_ODR); // R7
      pin_mask[p] = gpb_pin_mask(PORT_IDX_W'(p)); // R8 R9
    end
  end

  // Absent port 5 pins read low whatever the pad shows
  always_comb begin
    for (int p = 0; p < PORT_CNT; p++) begin
      pin_view[p] = pin_lvl[p] & pin_mask[p]; // R4
    end
  end

  // ----------------------------------------------------------------
  // Write strobes
  // ----------------------------------------------------------------

  // One strobe per register kind; pin-state writes have none
  assign slot_hit = slot_onehot(regs.slot);
  assign wr_dir = regs.wr & (regs.regn == GPB_REG_DIR); // R2
  assign wr_latch = regs.wr & (regs.regn == GPB_REG_LATCH); // R3
  assign wr_pullup = regs.wr & (regs.regn == GPB_REG_PULLUP); // R6
  assign wr_odr = regs.wr & (regs.regn == GPB_REG_ODR); // R7

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------

  // Only implemented bits store; others stay at zero for good
  always_comb begin
    nxt_ff = cur_ff;
    for (int p = 0; p < PORT_CNT; p++) begin
      if (wr_dir && slot_hit[p]) begin
        nxt_ff.dir[p] = regs.wdata & out_mask[p]; // R2 R5
      end
      if (wr_latch && slot_hit[p]) begin
        nxt_ff.output_latch_reg[p] = regs.wdata & out_mask[p]; // R3 R5
      end
      if (wr_pullup && slot_hit[p]) begin
        nxt_ff.pullup_control_reg[p] = regs.wdata & pup_mask[p]; // R6
      end
      if (wr_odr && slot_hit[p]) begin
        nxt_ff.open_drain_control_reg[p] = regs.wdata & odr_mask[p]; // R7
      end
    end
  end

  // All pins come out of reset as inputs with features off
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cur_ff.dir <= {PORT_CNT{RST_DIR}}; // R9
      cur_ff.output_latch_reg <= {PORT_CNT{RST_LATCH}}; // R9
      cur_ff.pullup_control_reg <= {PORT_CNT{RST_PULLUP}}; // R9
      cur_ff.open_drain_control_reg <= {PORT_CNT{RST_ODR}}; // R9
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------

  // One pick per kind; an index past the map never reaches the mux
  assign rd_dir = cur_ff.dir[regs.slot]; // R2
  assign rd_latch = cur_ff.output_latch_reg[regs.slot]; // R3
  assign rd_pin = pin_view[regs.slot]; // R4 R1
  assign rd_pullup = cur_ff.pullup_control_reg[regs.slot]; // R6
  assign rd_odr = cur_ff.open_drain_control_reg[regs.slot]; // R7

  // Absent registers and absent pins read as zero
  always_comb begin
    case (regs.regn)
      GPB_REG_DIR: begin
        regs.rdata = rd_dir; // R2
      end
      GPB_REG_LATCH: begin
        regs.rdata = rd_latch; // R3
      end
      GPB_REG_PIN: begin
        // Every port, input-only ones too, shows its pins
        regs.rdata = rd_pin; // R4
      end
      GPB_REG_PULLUP: begin
        regs.rdata = rd_pullup; // R6
      end
      GPB_REG_ODR: begin
        regs.rdata = rd_odr; // R7
      end
      default: begin
        regs.rdata = RST_PIN;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------

  // An open-drain pin holding a one lets go rather than drive high
  always_comb begin
    for (int p = 0; p < PORT_CNT; p++) begin
      high_off[p] = cur_ff.open_drain_control_reg[p] & cur_ff.output_latch_reg[p]; // R7
      drive_en[p] = cur_ff.dir[p] & ~high_off[p]; // R2
    end
  end

  // Output value and active-low enable per pin
  always_comb begin
    for (int p = 0; p < PORT_CNT; p++) begin
      pin_out[p] = cur_ff.output_latch_reg[p] & cur_ff.dir[p]; // R3
      pin_oe_n[p] = ~drive_en[p]; // R2 R7
    end
  end

  // ----------------------------------------------------------------
  // Pull-up switches
  // ----------------------------------------------------------------

  // Pull-up only helps an input; on a driven pin it just burns current
  always_comb begin
    for (int p = 0; p < PORT_CNT; p++) begin
      pullup_on[p] = cur_ff.pullup_control_reg[p] & ~cur_ff.dir[p]; // R6
    end
  end

endmodule

// >>> test/gpb_monitor.sv
`timescale 1ns/1ns
module gpb_monitor
  import gpb_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [WB_DAT_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Pins
  input wire logic [PORT_CNT-1:0][PIN_W-1:0] pin_out,
  input wire logic [PORT_CNT-1:0][PIN_W-1:0] pin_oe_n,
  input wire logic [PORT_CNT-1:0][PIN_W-1:0] pullup_on
);
  // ----------------
  // Checks
  // ----------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic req;
  logic od_bad;
  logic pup_bad;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Slots lacking a feature must never show it
  always_comb begin
    od_bad = 1'b0;
    pup_bad = 1'b0;
    for (int s = 0; s < PORT_CNT; s++) begin
      if (!(s == 2 || (s >= 6 && s <= 8)) && |(pin_out[s] & pin_oe_n[s])) begin
        od_bad = 1'b1;
      end
      if (!(s >= 6 && s <= 10) && |pullup_on[s]) begin
        pup_bad = 1'b1;
      end
    end
  end
  sequence s_taken;
    req;
  endsequence
  sequence s_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  ack_answer_a: assert property (s_taken |=> s_pulse)
    else $error("ack not one cycle after request");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(req))
    else $error("ack without request");
  byte_read_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("read data above low byte");
  input_only_a: assert property (pin_oe_n[SLOT_P4] == 8'hFF && pin_oe_n[SLOT_P9] == 8'hFF)
    else $error("input-only port drives");
  port5_width_a: assert property (pin_oe_n[SLOT_P5][7:3] == 5'h1F)
    else $error("absent port 5 pin driven");
  pin_write_a: assert property (!$stable(pin_oe_n) || !$stable(pin_out) || !$stable(pullup_on)
    |-> $past(req && wb_we_i))
    else $error("pin control changed without write");
  pullup_out_a: assert property ((pullup_on & ~pin_oe_n) == '0 && !pup_bad)
    else $error("pull-up on driven pin or wrong port");
  open_drain_a: assert property (!od_bad)
    else $error("released high pin on port without open-drain");
  reset_state_a: assert property ($fell(rst) |-> &pin_oe_n && pullup_on == '0 && pin_out == '0)
    else $error("pins not idle after reset");
endmodule

bind gpb_top gpb_monitor u_mon (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pullup_on(pullup_on));

// >>> test/gpb_board.sv
`timescale 1ns/1ns
module gpb_board
  import gpb_pkg::*;
(
  // Clock and board drive enable
  input wire logic ref_clk,
  input wire logic ext_en,
  // Pins as the device sees them
  input wire logic [PORT_CNT-1:0][PIN_W-1:0] pin_out,
  input wire logic [PORT_CNT-1:0][PIN_W-1:0] pin_oe_n,
  input wire logic [PORT_CNT-1:0][PIN_W-1:0] pullup_on,
  output logic [PORT_CNT-1:0][PIN_W-1:0] pin_in
);
  // ----------------
  // Wire level
  // ----------------
  logic tog = 1'b0;
  // Floating lines wander so a stale level never passes for a driven one
  always @(posedge ref_clk) begin
    tog <= ~tog;
  end
  // Device driver wins, then the board pattern, then the pull-up
  always_comb begin
    for (int s = 0; s < PORT_CNT; s++) begin
      for (int b = 0; b < PIN_W; b++) begin
        if (!pin_oe_n[s][b]) begin
          pin_in[s][b] = pin_out[s][b];
        end else if (ext_en) begin
          pin_in[s][b] = 1'((8'hC3 ^ 8'(s)) >> b);
        end else begin
          pin_in[s][b] = pullup_on[s][b] | tog;
        end
      end
    end
  end
endmodule

// >>> test/tb_gpio_port_set.sv
`timescale 1ns/1ns
module tb_gpio_port_set;
  import gpb_pkg::*;
  // ----------------
  // Signals
  // ----------------
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [WB_SEL_W-1:0] wb_sel_i = 4'hF;
  logic [WB_DAT_W-1:0] wb_dat_i = 32'h0;
  logic [WB_DAT_W-1:0] wb_dat_o;
  logic [WB_DAT_W-1:0] rd;
  logic wb_ack_o;
  logic ext_en = 1'b1;
  logic [PORT_CNT-1:0][PIN_W-1:0] pin_in, pin_out, pin_oe_n, pullup_on;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;

  gpb_top u_dut (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pullup_on(pullup_on));
  gpb_board u_board (.ref_clk(ref_clk), .ext_en(ext_en), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pullup_on(pullup_on), .pin_in(pin_in));

  // ----------------
  // Tasks
  // ----------------
  task automatic final_report();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [WB_DAT_W-1:0] got, input logic [WB_DAT_W-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle; ack is read before this edge's updates land
  task automatic bus(input logic we, input logic [11:0] adr, input logic [7:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h000000, d};
    @(posedge ref_clk);
    while (wb_ack_o !== 1'b1) begin
      @(posedge ref_clk);
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge ref_clk);
  endtask

  function automatic logic [11:0] ra(input int s, input logic [4:0] o);
    ra = 12'(s * 32) | 12'(o);
  endfunction

  // ----------------
  // Run
  // ----------------
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end

  // Hang guard, far above the roughly 700 cycles needed
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      final_report();
    end
  end

  initial begin
    logic [7:0] m, dir, od, pu;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    for (int s = 0; s < PORT_CNT; s++) begin
      m = (s == 4) ? 8'h07 : 8'hFF;
      dir = (s == 3 || s == 5) ? 8'h00 : m;
      od = (s == 2 || (s >= 6 && s <= 8)) ? m : 8'h00;
      pu = (s >= 6 && s <= 10) ? m : 8'h00;
      bus(0, ra(s, OFS_DIR), 8'h00);
      chk(rd, 0);
      bus(1, ra(s, OFS_DIR), 8'hFF);
      bus(0, ra(s, OFS_DIR), 8'h00);
      chk(rd, dir);
      chk(pin_oe_n[s] ^ dir, 8'hFF);
      bus(1, ra(s, OFS_LATCH), 8'h5A);
      bus(0, ra(s, OFS_LATCH), 8'h00);
      chk(rd, 8'h5A & dir);
      chk(pin_out[s], 8'h5A & dir);
      repeat (4) @(posedge ref_clk);
      bus(0, ra(s, OFS_PIN), 8'h00);
      chk(rd, (8'h5A & dir) | ((8'hC3 ^ 8'(s)) & ~dir & m));
      bus(1, ra(s, OFS_ODR), 8'hFF);
      bus(0, ra(s, OFS_ODR), 8'h00);
      chk(rd, od);
      chk(pin_oe_n[s] ^ (dir & ~(od & 8'h5A)), 8'hFF);
      bus(1, ra(s, OFS_PULLUP), 8'hFF);
      bus(0, ra(s, OFS_PULLUP), 8'h00);
      chk(rd, pu);
      bus(1, ra(s, OFS_DIR), 8'h00);
      chk(pullup_on[s], pu);
      repeat (4) @(posedge ref_clk);
      bus(0, ra(s, OFS_PIN), 8'h00);
      chk(rd, (8'hC3 ^ 8'(s)) & m);
    end
    // Board lets go; only the pull-up holds port A high
    ext_en <= 1'b0;
    repeat (6) @(posedge ref_clk);
    bus(0, ra(6, OFS_PIN), 8'h00);
    chk(rd, 8'hFF);
    bus(0, 12'h1E0, 8'h00);
    chk(rd, 0);
    // A write with byte lane 0 off is acked but must store nothing
    wb_sel_i <= 4'hE;
    bus(1, ra(0, OFS_DIR), 8'hFF);
    wb_sel_i <= 4'hF;
    bus(0, ra(0, OFS_DIR), 8'h00);
    chk(rd, 8'h00);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    bus(0, ra(6, OFS_PULLUP), 8'h00);
    chk(rd, 0);
    final_report();
  end
endmodule
